// >>> assj_axis.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ns
module assj_axis
	import assj_pkg::*;
#(
	parameter int SCAN_CYCLES = SCAN_CYC
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic op_done,
	output logic busy,
	output logic [2:0] op_status,
	output logic [7:0] error_number,
	output logic sudden_active,
	output logic [15:0] decel_time,
	output logic [15:0] cmd_speed,
	output logic [15:0] arc_centre_x,
	output logic [15:0] arc_centre_y,
	output logic [15:0] arc_end_x,
	output logic [15:0] arc_end_y,
	output logic irq
);

	if (SCAN_CYCLES < 1) begin : g_scan_check
		$error("SCAN_CYCLES must be at least 1");
	end

	assj_apb_req_s req;
	assign req = '{paddr, psel, penable, pwrite, pwdata};

	logic wr_en;
	logic rd_en;
	assign wr_en = req.psel && req.penable && req.pwrite;
	assign rd_en = req.psel && req.penable && !req.pwrite;

	logic [31:0] ctrl;
	logic [5:0] stop_select;
	logic [15:0] speed_reg;
	logic [15:0] jog_speed_ceiling;
	logic [15:0] axis_speed_ceiling;
	logic [15:0] sudden_stop_decel_time;
	logic [15:0] norm_decel;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic [15:0] droop_count;
	assj_point_s arc_start;
	assj_point_s arc_centre_rel;
	assj_point_s arc_end_rel;
	logic op_done_s1;
	logic op_done_s2;

	assj_state_e state;
	logic start_q;
	logic stop_q;
	logic jog_q;
	logic [1:0] latched_sel;
	logic [EV_W-1:0] ev;

	wire logic start_req = ctrl[CB_START];
	wire logic stop_req = ctrl[CB_STOP];
	wire logic jog_req = ctrl[CB_JOG];
	wire logic [1:0] stop_grp = ctrl[CB_STOPGRP_LO +: 2];
	wire logic start_rise = start_req && !start_q;
	wire logic stop_rise = stop_req && !stop_q;
	wire logic jog_rise = jog_req && !jog_q;

	function automatic logic [1:0] grp_sel(input logic [5:0] sel,
		input logic [1:0] grp);
		logic [1:0] r;
		r = 2'h0;
		case (grp)
			2'h1: r = sel[1:0];
			2'h2: r = sel[3:2];
			2'h3: r = sel[5:4];
			default: r = sel[1:0];
		endcase
		return r;
	endfunction : grp_sel

	// apb write side
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl <= '0;
			stop_select <= '0;
			jog_speed_ceiling <= '0;
			axis_speed_ceiling <= '0;
			sudden_stop_decel_time <= DECEL_RST;
			norm_decel <= DECEL_RST;
			irq_mask <= '0;
			droop_count <= '0;
			arc_start <= '0;
		end else if (wr_en) begin
			unique case (req.paddr)
				OFS_CTRL: ctrl <= req.pwdata;
				OFS_STOPSEL: stop_select <= req.pwdata[5:0];
				OFS_JOGLIM: jog_speed_ceiling <= req.pwdata[15:0];
				OFS_AXLIM: axis_speed_ceiling <= req.pwdata[15:0];
				OFS_DECEL: begin
					norm_decel <= req.pwdata[15:0];
					sudden_stop_decel_time <= req.pwdata[31:16];
				end
				OFS_IRQMSK: irq_mask <= req.pwdata[EV_W-1:0];
				OFS_DROOP: droop_count <= req.pwdata[15:0];
				OFS_ARC: arc_start <= req.pwdata;
				default: ;
			endcase
		end else if (state == ASSJ_DROOP && droop_count != '0) begin
			droop_count <= droop_count - 16'h0001;
		end
	end

	// speed change only while idle or while changeover indication is on
	always_ff @(posedge clock) begin
		if (srst) begin
			speed_reg <= SPEED_RST;
		end else if (wr_en && req.paddr == OFS_SPEED && state == ASSJ_IDLE) begin
			speed_reg <= req.pwdata[15:0];
		end else if (wr_en && req.paddr == OFS_SPEED && ctrl[CB_CHGOVR]) begin
			speed_reg <= req.pwdata[15:0];
		end
	end

	// incremental arc: offsets relative to arc start
	always_ff @(posedge clock) begin
		if (srst) begin
			arc_centre_rel <= '0;
			arc_end_rel <= '0;
		end else if (wr_en && req.paddr == OFS_ARC) begin
			arc_centre_rel <= '0;
			arc_end_rel <= '0;
		end else if (wr_en && req.paddr == OFS_ARC_CEN) begin
			arc_centre_rel <= req.pwdata;
		end else if (wr_en && req.paddr == OFS_ARC_END) begin
			arc_end_rel <= req.pwdata;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			arc_centre_x <= '0;
			arc_centre_y <= '0;
			arc_end_x <= '0;
			arc_end_y <= '0;
		end else begin
			arc_centre_x <= arc_start.x + arc_centre_rel.x;
			arc_centre_y <= arc_start.y + arc_centre_rel.y;
			arc_end_x <= arc_start.x + arc_end_rel.x;
			arc_end_y <= arc_start.y + arc_end_rel.y;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			op_done_s1 <= 1'b0;
			op_done_s2 <= 1'b0;
			start_q <= 1'b0;
			stop_q <= 1'b0;
			jog_q <= 1'b0;
		end else begin
			op_done_s1 <= op_done;
			op_done_s2 <= op_done_s1;
			start_q <= start_req;
			stop_q <= stop_req;
			jog_q <= jog_req;
		end
	end

	// axis sequencer
	always_ff @(posedge clock) begin
		if (srst) begin
			state <= ASSJ_IDLE;
			busy <= 1'b0;
			error_number <= ERR_NONE;
			latched_sel <= 2'h0;
			sudden_active <= 1'b0;
			decel_time <= DECEL_RST;
			ev <= '0;
		end else begin
			ev <= '0;
			unique case (state)
				ASSJ_IDLE: begin
					if (jog_rise) begin
						if (jog_speed_ceiling > axis_speed_ceiling) begin
							error_number <= ERR_JOG_LIMIT;
							ev[EV_ERR] <= 1'b1;
						end else begin
							busy <= 1'b1;
							error_number <= ERR_NONE;
							ev[EV_START] <= 1'b1;
							state <= ASSJ_DROOP;
						end
					end else if (start_rise) begin
						busy <= 1'b1;
						error_number <= ERR_NONE;
						ev[EV_START] <= 1'b1;
						state <= ASSJ_RUN;
					end
				end
				ASSJ_DROOP: begin
					if (stop_rise) begin
						state <= ASSJ_IDLE;
						busy <= 1'b0;
						ev[EV_DONE] <= 1'b1;
					end else if (droop_count == '0) begin
						state <= ASSJ_RUN;
					end
				end
				ASSJ_RUN: begin
					if (start_rise) begin
						error_number <= ERR_BUSY_START;
						ev[EV_ERR] <= 1'b1;
					end
					if (stop_rise) begin
						latched_sel <= grp_sel(stop_select, stop_grp);
						if (grp_sel(stop_select, stop_grp) == SEL_SUDDEN) begin
							state <= ASSJ_SUDDEN;
							sudden_active <= 1'b1;
							decel_time <= sudden_stop_decel_time;
						end else begin
							state <= ASSJ_DECEL;
							decel_time <= norm_decel;
						end
					end else if (op_done_s2) begin
						state <= ASSJ_IDLE;
						busy <= 1'b0;
						ev[EV_DONE] <= 1'b1;
					end
				end
				ASSJ_DECEL, ASSJ_SUDDEN: begin
					// repeated stop is ignored; latched choice is kept
					if (op_done_s2) begin
						state <= ASSJ_IDLE;
						busy <= 1'b0;
						sudden_active <= 1'b0;
						ev[EV_DONE] <= 1'b1;
					end
				end
				default: state <= ASSJ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			op_status <= 3'h0;
		end else begin
			op_status <= state;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cmd_speed <= SPEED_RST;
		end else begin
			cmd_speed <= speed_reg;
		end
	end

	// sticky events, set wins over write-one-to-clear
	always_ff @(posedge clock) begin
		if (srst) begin
			irq_status <= '0;
		end else if (wr_en && req.paddr == OFS_IRQST) begin
			irq_status <= (irq_status & ~req.pwdata[EV_W-1:0]) | ev;
		end else begin
			irq_status <= irq_status | ev;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// apb read side; zero wait states
	always_ff @(posedge clock) begin
		if (srst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= req.psel && !req.penable;
			pslverr <= 1'b0;
			if (req.psel && !req.penable && !req.pwrite) begin
				unique case (req.paddr)
					OFS_CTRL: prdata <= ctrl;
					OFS_STAT: prdata <= {11'h000, sudden_active, latched_sel,
						error_number, 5'h00, state, 1'b0, busy};
					OFS_STOPSEL: prdata <= {26'h0, stop_select};
					OFS_SPEED: prdata <= {16'h0000, speed_reg};
					OFS_JOGLIM: prdata <= {16'h0000, jog_speed_ceiling};
					OFS_AXLIM: prdata <= {16'h0000, axis_speed_ceiling};
					OFS_DECEL: prdata <= {sudden_stop_decel_time, norm_decel};
					OFS_IRQST: prdata <= {29'h0, irq_status};
					OFS_IRQMSK: prdata <= {29'h0, irq_mask};
					OFS_DROOP: prdata <= {16'h0000, droop_count};
					OFS_ARC: prdata <= arc_start;
					default: begin
						prdata <= '0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	logic unused_rd;
	assign unused_rd = rd_en;

	property p_start_edge;
		@(posedge clock) disable iff (srst)
		(state == ASSJ_IDLE && start_req && start_q && !jog_rise) |=> !busy;
	endproperty
	AST_START_EDGE: assert property (p_start_edge)
		else $error("busy rose without start edge");

	sequence s_run_stop;
		state == ASSJ_RUN && stop_rise && !op_done_s2;
	endsequence
	AST_SUDDEN_SEL: assert property (@(posedge clock) disable iff (srst)
		s_run_stop ##0 (grp_sel(stop_select, stop_grp) == SEL_SUDDEN)
		|=> state == ASSJ_SUDDEN && decel_time == $past(sudden_stop_decel_time))
		else $error("sudden select not honoured");
	AST_STOP_HOLD: assert property (@(posedge clock) disable iff (srst)
		(state == ASSJ_DECEL && !op_done_s2) |=> state == ASSJ_DECEL)
		else $error("deceleration stop changed");
	AST_SPEED_GATE: assert property (@(posedge clock) disable iff (srst)
		(state != ASSJ_IDLE && !ctrl[CB_CHGOVR]) |=> $stable(speed_reg))
		else $error("speed changed before changeover");
	// end offset written two cycles back must appear added to the arc start
	AST_ARC_REL: assert property (@(posedge clock) disable iff (srst)
		(wr_en && req.paddr == OFS_ARC_END) |=> ##1
		arc_end_x == arc_start.x + $past(req.pwdata[31:16], 2))
		else $error("arc end not relative to start");
	AST_DROOP_WAIT: assert property (@(posedge clock) disable iff (srst)
		(state == ASSJ_DROOP && droop_count != '0) |=> state != ASSJ_RUN)
		else $error("jog moved before droop cleared");
	AST_JOG_LIMIT: assert property (@(posedge clock) disable iff (srst)
		(state == ASSJ_IDLE && jog_rise && jog_speed_ceiling > axis_speed_ceiling)
		|=> !busy && error_number == ERR_JOG_LIMIT)
		else $error("jog limit not refused");
	AST_BUSY_DONE: assert property (@(posedge clock) disable iff (srst)
		(state == ASSJ_RUN && op_done_s2 && !stop_rise) |=> !busy ##1 irq_status[EV_DONE])
		else $error("busy did not drop at completion");

endmodule : assj_axis

// >>> assj_axis_tb_top.sv
`timescale 1ns/1ns
module assj_axis_tb_top;
	import assj_pkg::*;
	logic clock, srst, psel, penable, pwrite, op_done, pready, pslverr;
	logic busy, sudden_active, irq, err;
	logic [7:0] paddr, error_number;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] op_status;
	logic [15:0] decel_time, cmd_speed, cx, cy, ex, ey, dly;
	int failures, samples_checked, cycles;
	// one scaled scan stands for 1 ms; stop is held four of them
	localparam int SCAN = 100;
	localparam int STOP_HOLD = 4 * SCAN;

	assj_axis #(.SCAN_CYCLES(SCAN)) assj_axis_i (.clock(clock), .srst(srst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_done(op_done), .busy(busy),
		.op_status(op_status), .error_number(error_number),
		.sudden_active(sudden_active), .decel_time(decel_time),
		.cmd_speed(cmd_speed), .arc_centre_x(cx), .arc_centre_y(cy),
		.arc_end_x(ex), .arc_end_y(ey), .irq(irq));
	assj_motion_model assj_motion_model_i (.clock(clock), .srst(srst),
		.busy(busy), .delay(dly), .op_done(op_done));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			finish_test();
		end
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wt(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wt

	task wait_busy(input logic v);
		for (int i = 0; i < 2000 && busy !== v; i++) @(posedge clock);
		#1;
	endtask : wait_busy

	task t_start;
		dly <= 16'h0014;
		apb(1'b1, OFS_CTRL, 32'h1);
		wait_busy(1'b1);
		chk("busy", 32'h1, busy);
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1);
		wt(3);
		chk("error_number", ERR_BUSY_START, error_number);
		wait_busy(1'b0);
		chk("busy", 32'h0, busy);
		wt(10);
		chk("busy", 32'h0, busy);
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask : t_start

	task t_stop(input logic [1:0] sel);
		dly <= 16'h03E8;
		apb(1'b1, OFS_STOPSEL, {30'h0, sel});
		apb(1'b1, OFS_CTRL, 32'h1);
		wait_busy(1'b1);
		apb(1'b1, OFS_CTRL, 32'h102);
		wt(3);
		chk("op_status", sel == SEL_SUDDEN ? ASSJ_SUDDEN : ASSJ_DECEL,
			op_status);
		chk("sudden_active", sel == SEL_SUDDEN, sudden_active);
		chk("decel_time", sel == SEL_SUDDEN ? 32'h7 : 32'h50,
			decel_time);
		if (sel != SEL_SUDDEN) begin
			wt(STOP_HOLD);
			chk("busy", 32'h1, busy);
			apb(1'b1, OFS_STOPSEL, {30'h0, SEL_SUDDEN});
			apb(1'b1, OFS_CTRL, 32'h100);
			apb(1'b1, OFS_CTRL, 32'h102);
			wt(3);
			chk("op_status", ASSJ_DECEL, op_status);
			chk("sudden_active", 32'h0, sudden_active);
		end
		wait_busy(1'b0);
		chk("busy", 32'h0, busy);
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask : t_stop

	task t_speed;
		dly <= 16'h0064;
		apb(1'b1, OFS_CTRL, 32'h1);
		wait_busy(1'b1);
		apb(1'b1, OFS_SPEED, 32'h1234);
		wt(2);
		chk("cmd_speed", SPEED_RST, cmd_speed);
		apb(1'b1, OFS_CTRL, 32'h11);
		apb(1'b1, OFS_SPEED, 32'h1234);
		wt(2);
		chk("cmd_speed", 32'h1234, cmd_speed);
		wait_busy(1'b0);
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask : t_speed

	task t_arc;
		apb(1'b1, OFS_ARC, 32'h0010_0020);
		apb(1'b1, OFS_ARC_CEN, 32'h0003_0004);
		apb(1'b1, OFS_ARC_END, 32'h0005_0006);
		wt(2);
		chk("arc_centre_x", 32'h13, cx);
		chk("arc_centre_y", 32'h24, cy);
		chk("arc_end_x", 32'h15, ex);
		chk("arc_end_y", 32'h26, ey);
	endtask : t_arc

	task t_jog;
		int n;
		// clear events left by earlier scenarios so the error bit is fresh
		apb(1'b1, OFS_IRQST, 32'h7);
		apb(1'b1, OFS_AXLIM, 32'h100);
		apb(1'b1, OFS_JOGLIM, 32'h200);
		apb(1'b1, OFS_CTRL, 32'h4);
		wt(3);
		chk("error_number", ERR_JOG_LIMIT, error_number);
		chk("busy", 32'h0, busy);
		chk("irq", 32'h0, irq);
		apb(1'b1, OFS_IRQMSK, 32'h4);
		wt(2);
		chk("irq", 32'h1, irq);
		apb(1'b0, OFS_IRQST, 32'h0);
		chk("irq_status_err", 32'h1, rd[EV_ERR]);
		apb(1'b1, OFS_IRQST, 32'h4);
		wt(2);
		chk("irq", 32'h0, irq);
		apb(1'b0, 8'h3C, 32'h0);
		chk("pslverr", 32'h1, err);
		dly <= 16'h001E;
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_JOGLIM, 32'h80);
		apb(1'b1, OFS_DROOP, 32'h14);
		apb(1'b1, OFS_CTRL, 32'h4);
		wt(3);
		chk("op_status", ASSJ_DROOP, op_status);
		for (n = 0; n < 40 && op_status !== ASSJ_RUN; n++) @(posedge clock);
		chk("droop_wait_long", 32'h1, n >= 14);
		chk("op_status", ASSJ_RUN, op_status);
		wait_busy(1'b0);
	endtask : t_jog

	task finish_test;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dly = 16'd20;
		failures = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		wt(1);
		chk("busy", 32'h0, busy);
		chk("decel_time", DECEL_RST, decel_time);
		apb(1'b1, OFS_DECEL, 32'h0007_0050);
		t_start();
		t_stop(2'h0);
		t_stop(SEL_SUDDEN);
		t_speed();
		t_arc();
		t_jog();
		finish_test();
	end
endmodule : assj_axis_tb_top

// >>> assj_motion_model.sv
`timescale 1ns/1ns
// drive-side stand-in: reports motion finished a set time after busy rises
module assj_motion_model (
	input wire logic clock,
	input wire logic srst,
	input wire logic busy,
	input wire logic [15:0] delay,
	output logic op_done
);
	logic [15:0] cnt;
	always_ff @(posedge clock) begin
		if (srst || !busy) begin
			cnt <= 16'h0000;
			op_done <= 1'b0;
		end else begin
			cnt <= cnt + 16'h0001;
			op_done <= (cnt >= delay);
		end
	end
endmodule : assj_motion_model

// >>> assj_pkg.sv
package assj_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_STOPSEL = 8'h08;
	localparam logic [7:0] OFS_SPEED = 8'h0C;
	localparam logic [7:0] OFS_JOGLIM = 8'h10;
	localparam logic [7:0] OFS_AXLIM = 8'h14;
	localparam logic [7:0] OFS_DECEL = 8'h18;
	localparam logic [7:0] OFS_IRQST = 8'h1C;
	localparam logic [7:0] OFS_IRQMSK = 8'h20;
	localparam logic [7:0] OFS_DROOP = 8'h24;
	localparam logic [7:0] OFS_ARC = 8'h28;
	localparam logic [7:0] OFS_ARC_CEN = 8'h5C;
	localparam logic [7:0] OFS_ARC_END = 8'h60;

	// control register bits
	localparam int CB_START = 0;
	localparam int CB_STOP = 1;
	localparam int CB_JOG = 2;
	localparam int CB_JOGDIR = 3;
	localparam int CB_CHGOVR = 4;
	localparam int CB_SPDCHG = 5;
	localparam int CB_STOPGRP_LO = 8;

	// interrupt event bits
	localparam int EV_START = 0;
	localparam int EV_DONE = 1;
	localparam int EV_ERR = 2;
	localparam int EV_W = 3;

	localparam logic [1:0] SEL_SUDDEN = 2'h1;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_JOG_LIMIT = 8'h01;
	localparam logic [7:0] ERR_BUSY_START = 8'h02;
	localparam logic [15:0] DECEL_RST = 16'h0064;
	localparam logic [15:0] SPEED_RST = 16'h0000;

	localparam int CLK_MHZ = 100;
	localparam int SCAN_US = 1000;
	localparam int SCAN_CYC = CLK_MHZ * SCAN_US;

	typedef enum logic [2:0] {
		ASSJ_IDLE = 3'b000,
		ASSJ_RUN = 3'b001,
		ASSJ_DROOP = 3'b010,
		ASSJ_DECEL = 3'b011,
		ASSJ_SUDDEN = 3'b100
	} assj_state_e;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} assj_apb_req_s;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
	} assj_point_s;

endpackage : assj_pkg
